// ==== hdl/gio_pkg.sv ====
// Purpose: Shared constants of the general I/O port with sleep hold
// Assumes: AXI4-Lite register window of 8 address bits, 32-bit data
// Notes: All offsets are byte addresses of aligned words
package gio_pkg;
	// Port geometry
	localparam int NPIN = 20;
	localparam int NDO = 2;
	localparam int NPER = 4;
	localparam int AW = 8;
	// Register byte offsets
	localparam logic [7:0] A_DIR = 8'h00;
	localparam logic [7:0] A_DOUT = 8'h04;
	localparam logic [7:0] A_PULL = 8'h08;
	localparam logic [7:0] A_PIN = 8'h0c;
	localparam logic [7:0] A_EDGE = 8'h10;
	localparam logic [7:0] A_ISTAT = 8'h14;
	localparam logic [7:0] A_ICLR = 8'h18;
	localparam logic [7:0] A_IEN = 8'h1c;
	localparam logic [7:0] A_PER_EN = 8'h20;
	localparam logic [7:0] A_PER_ALT = 8'h24;
	localparam logic [7:0] A_PER_REL = 8'h28;
	localparam logic [7:0] A_CTRL = 8'h2c;
	localparam logic [7:0] A_DO = 8'h30;
	localparam logic [7:0] A_WORD_MASK = 8'hfc;
	// Field positions
	localparam int CTRL_RF_BIT = 0;
	localparam int RF_TX_PIN = 3;
	localparam int RF_RX_PIN = 2;
	// Reset values
	localparam logic [NPIN-1:0] PULL_RST = {NPIN{1'b1}};
	localparam logic [NPIN-1:0] DIR_RST = {NPIN{1'b0}};
	localparam logic [NPIN-1:0] EDGE_RST = {NPIN{1'b0}};
	// Bus responses
	localparam logic [1:0] RESP_OKAY = 2'h0;
	localparam logic [1:0] RESP_SLVERR = 2'h2;
	// Power state
	typedef enum logic [0:0] {
		PWR_RUN = 1'b0,
		PWR_SLEEP = 1'b1
	} gio_pwr_t;
endpackage

// ==== hdl/gio_pin_sync.sv ====
// Purpose: Two-stage synchroniser with edge pulses for the pin inputs
// Assumes: One clock, synchronous active-low reset
// Notes: Edges are taken between the second and third stage only
`timescale 1ns/1ps
`default_nettype none
module gio_pin_sync #(
	parameter int W = gio_pkg::NPIN
) (
	// Clock and reset
	input wire logic aclk,
	input wire logic aresetn,
	// Raw pins
	input wire logic [W-1:0] d,
	// Clean level and one-cycle edge pulses
	output logic [W-1:0] level,
	output logic [W-1:0] rise,
	output logic [W-1:0] fall
);
	logic [W-1:0] s1_r;
	logic [W-1:0] s2_r;
	logic [W-1:0] s3_r;

	// First stage feeds only the second
	// Reset to the pulled-up idle level so release makes no false edge
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			s1_r <= '1;
			s2_r <= '1;
			s3_r <= '1;
		end else begin
			s1_r <= d;
			s2_r <= s1_r;
			s3_r <= s2_r;
		end
	end

	// One pulse per settled transition
	assign level = s2_r;
	assign rise = s2_r & ~s3_r;
	assign fall = ~s2_r & s3_r;
endmodule
`default_nettype wire

// ==== hdl/gio_port.sv ====
// Purpose: General I/O port with peripheral override, edge interrupts and sleep hold
// Assumes: Peripherals present their claim masks, enables and drive values on ports
// Notes: Sleep entry folds peripheral drive into the general registers
//
// Contract
// - Twenty bidirectional pins with own pull-up, plus two output-only pins.
// - An enabled peripheral drives direction and value of the pins it claims.
// - Each peripheral picks standard or alternative pin allocation by configuration.
// - Released pins stay with the general port while the peripheral runs.
// - Reset: peripherals off, all pins inputs, all pull-ups on.
// - Unclaimed pins: software sets direction, then reads or drives value.
// - Pull-ups set per pin by software and kept through sleep.
// - Input pins raise an enableable interrupt on the chosen edge.
// - During sleep enabled pin interrupts wake the device.
// - Pending pin interrupt status is readable.
// - Pin levels read back whether input or output.
// - Sleep holds direction and level as combined at sleep entry.
// - After wake the held values belong to general data and direction.
// - Peripherals stay off after wake until software enables them again.
// - Two pins may act as external radio front-end controls.
// - With radio control on, one pin shows transmit, another receive.
//
// The placing of the registers and the AXI4-Lite slave port were decided locally.
`timescale 1ns/1ps
`default_nettype none
module gio_port #(
	parameter int NPIN = gio_pkg::NPIN,
	parameter int NDO = gio_pkg::NDO,
	parameter int NPER = gio_pkg::NPER
) (
	// Clock and reset
	input wire logic aclk,
	input wire logic aresetn,
	// AXI4-Lite write channels
	input wire logic [gio_pkg::AW-1:0] awaddr,
	input wire logic awvalid,
	output logic awready,
	input wire logic [31:0] wdata,
	input wire logic [3:0] wstrb,
	input wire logic wvalid,
	output logic wready,
	output logic [1:0] bresp,
	output logic bvalid,
	input wire logic bready,
	// AXI4-Lite read channels
	input wire logic [gio_pkg::AW-1:0] araddr,
	input wire logic arvalid,
	output logic arready,
	output logic [31:0] rdata,
	output logic [1:0] rresp,
	output logic rvalid,
	input wire logic rready,
	// Pins
	input wire logic [NPIN-1:0] general_io_pin_in,
	output logic [NPIN-1:0] general_io_pin_out,
	output logic [NPIN-1:0] general_io_pin_oe,
	output logic [NPIN-1:0] pin_pullup_resistor_en,
	output logic [NDO-1:0] output_pin,
	// Peripherals
	output logic [NPER-1:0] per_enable,
	output logic [NPER-1:0] per_alt,
	input wire logic [NPER*NPIN-1:0] per_std_mask,
	input wire logic [NPER*NPIN-1:0] per_alt_mask,
	input wire logic [NPIN-1:0] per_oe,
	input wire logic [NPIN-1:0] per_out,
	// Radio state
	input wire logic radio_tx_active,
	input wire logic radio_rx_active,
	// Power and interrupt
	input wire logic sleep_req,
	output logic wake,
	output logic irq
);
	logic [NPIN-1:0] dir_r, dout_r, pull_r, edge_r, istat_r, ien_r, rel_r;
	logic [NPIN-1:0] oe_r, out_r, istat_nxt;
	logic [NPER-1:0] per_en_r, alt_r;
	logic [NDO-1:0] do_r;
	logic rf_en_r, irq_r, wake_r, irq_nxt;
	gio_pkg::gio_pwr_t pwr_r;
	logic aw_full_r, w_full_r, bvalid_r, awready_r, wready_r;
	logic [gio_pkg::AW-1:0] aw_addr_r;
	logic [31:0] w_data_r;
	logic [3:0] w_strb_r;
	logic arready_r, rvalid_r;
	logic [31:0] rdata_r;
	logic [1:0] rresp_r;
	logic [NPIN-1:0] lvl, rise, fall;

	// Byte-lane mask from strobes
	function automatic logic [31:0] lane_mask(input logic [3:0] s);
		lane_mask = {{8{s[3]}}, {8{s[2]}}, {8{s[1]}}, {8{s[0]}}};
	endfunction

	// Merge a write into a narrow register
	function automatic logic [NPIN-1:0] upd(input logic [NPIN-1:0] old, input logic [31:0] d,
		input logic [3:0] s);
		logic [31:0] m;
		m = lane_mask(s);
		upd = (old & ~m[NPIN-1:0]) | (d[NPIN-1:0] & m[NPIN-1:0]);
	endfunction

	// Pins claimed by enabled peripherals on their chosen allocation
	function automatic logic [NPIN-1:0] claim_of(input logic [NPER-1:0] en, input logic [NPER-1:0] alt,
		input logic [NPER*NPIN-1:0] sm, input logic [NPER*NPIN-1:0] am);
		claim_of = '0;
		for (int n = 0; n < NPER; n++) begin
			if (en[n]) begin
				claim_of = claim_of | (alt[n] ? am[n*NPIN +: NPIN] : sm[n*NPIN +: NPIN]);
			end
		end
	endfunction

	// Input synchroniser and edge finder
	gio_pin_sync #(.W(NPIN)) u_sync (
		.aclk(aclk),
		.aresetn(aresetn),
		.d(general_io_pin_in),
		.level(lvl),
		.rise(rise),
		.fall(fall)
	);

	// Power state decode
	wire running = (pwr_r == gio_pkg::PWR_RUN);
	wire enter_sleep = running && sleep_req;

	// Pin ownership; released pins go back to the general port
	wire [NPIN-1:0] rf_mask = rf_en_r ?
		(NPIN'(1) << gio_pkg::RF_TX_PIN) | (NPIN'(1) << gio_pkg::RF_RX_PIN) : '0;
	wire [NPIN-1:0] claim = claim_of(per_en_r, alt_r, per_std_mask, per_alt_mask) & ~rel_r & ~rf_mask;
	wire [NPIN-1:0] rf_val = (NPIN'(radio_tx_active) << gio_pkg::RF_TX_PIN) |
		(NPIN'(radio_rx_active) << gio_pkg::RF_RX_PIN);

	// Combined drive: radio controls, then peripherals, then general registers
	wire [NPIN-1:0] eff_oe = rf_mask | (claim & per_oe) | (~claim & ~rf_mask & dir_r);
	wire [NPIN-1:0] eff_out = (rf_mask & rf_val) | (claim & per_out) | (~claim & ~rf_mask & dout_r);

	// Write channel bookkeeping; address and data may come in either order
	wire aw_got = awvalid && awready_r;
	wire w_got = wvalid && wready_r;
	wire do_wr = aw_full_r && w_full_r && !bvalid_r;
	wire aw_full_nxt = (aw_full_r && !do_wr) || aw_got;
	wire w_full_nxt = (w_full_r && !do_wr) || w_got;
	wire [7:0] wa = aw_addr_r & gio_pkg::A_WORD_MASK;
	wire wr_ok = wa <= gio_pkg::A_DO;
	// Bits frozen during sleep so the held state is not disturbed
	wire wr_live = do_wr && running;
	wire wr_dir = wr_live && wa == gio_pkg::A_DIR;
	wire wr_dout = wr_live && wa == gio_pkg::A_DOUT;
	wire wr_pull = do_wr && wa == gio_pkg::A_PULL;
	wire wr_edge = do_wr && wa == gio_pkg::A_EDGE;
	wire wr_iclr = do_wr && wa == gio_pkg::A_ICLR;
	wire wr_ien = do_wr && wa == gio_pkg::A_IEN;
	wire wr_pen = wr_live && wa == gio_pkg::A_PER_EN;
	wire wr_alt = wr_live && wa == gio_pkg::A_PER_ALT;
	wire wr_rel = wr_live && wa == gio_pkg::A_PER_REL;
	wire wr_ctrl = wr_live && wa == gio_pkg::A_CTRL;
	wire wr_do = wr_live && wa == gio_pkg::A_DO;
	wire [31:0] wm = w_data_r & lane_mask(w_strb_r);

	// Read channel decode
	wire ar_got = arvalid && arready_r;
	wire rvalid_nxt = ar_got || (rvalid_r && !rready);
	wire [7:0] ra = araddr & gio_pkg::A_WORD_MASK;
	wire rd_ok = ra <= gio_pkg::A_DO;
	wire [31:0] rd_word =
		ra == gio_pkg::A_DIR ? 32'(dir_r) :
		ra == gio_pkg::A_DOUT ? 32'(dout_r) :
		ra == gio_pkg::A_PULL ? 32'(pull_r) :
		ra == gio_pkg::A_PIN ? 32'(lvl) :
		ra == gio_pkg::A_EDGE ? 32'(edge_r) :
		ra == gio_pkg::A_ISTAT ? 32'(istat_r) :
		ra == gio_pkg::A_IEN ? 32'(ien_r) :
		ra == gio_pkg::A_PER_EN ? 32'(per_en_r) :
		ra == gio_pkg::A_PER_ALT ? 32'(alt_r) :
		ra == gio_pkg::A_PER_REL ? 32'(rel_r) :
		ra == gio_pkg::A_CTRL ? 32'(rf_en_r) :
		ra == gio_pkg::A_DO ? 32'(do_r) : 32'h0000_0000;

	// Edge events only on pins acting as inputs; a new event beats a clear
	wire [NPIN-1:0] ev = ~oe_r & ((edge_r & rise) | (~edge_r & fall));
	assign istat_nxt = (istat_r & ~(wr_iclr ? wm[NPIN-1:0] : '0)) | ev;
	assign irq_nxt = |(istat_nxt & ien_r);

	// Bus handshake state
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			aw_full_r <= 1'b0;
			w_full_r <= 1'b0;
			awready_r <= 1'b1;
			wready_r <= 1'b1;
			bvalid_r <= 1'b0;
			arready_r <= 1'b1;
			rvalid_r <= 1'b0;
		end else begin
			aw_full_r <= aw_full_nxt;
			w_full_r <= w_full_nxt;
			awready_r <= !aw_full_nxt;
			wready_r <= !w_full_nxt;
			bvalid_r <= do_wr || (bvalid_r && !bready);
			arready_r <= !rvalid_nxt;
			rvalid_r <= rvalid_nxt;
		end
	end

	// Bus payload holding
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			aw_addr_r <= '0;
			w_data_r <= '0;
			w_strb_r <= '0;
			rdata_r <= '0;
			rresp_r <= gio_pkg::RESP_OKAY;
		end else begin
			if (aw_got) aw_addr_r <= awaddr;
			if (w_got) w_data_r <= wdata;
			if (w_got) w_strb_r <= wstrb;
			if (ar_got) rdata_r <= rd_word;
			if (ar_got) rresp_r <= rd_ok ? gio_pkg::RESP_OKAY : gio_pkg::RESP_SLVERR;
		end
	end

	// Response code of the pending write
	logic [1:0] bresp_r;
	always_ff @(posedge aclk) begin
		if (!aresetn) bresp_r <= gio_pkg::RESP_OKAY;
		else if (do_wr) bresp_r <= wr_ok ? gio_pkg::RESP_OKAY : gio_pkg::RESP_SLVERR;
	end

	// Sleep entry folds the combined drive into the general registers
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			pwr_r <= gio_pkg::PWR_RUN;
			dir_r <= gio_pkg::DIR_RST;
			dout_r <= '0;
			per_en_r <= '0;
			rf_en_r <= 1'b0;
		end else if (enter_sleep) begin
			pwr_r <= gio_pkg::PWR_SLEEP;
			dir_r <= eff_oe;
			dout_r <= eff_out;
			per_en_r <= '0;
			rf_en_r <= 1'b0;
		end else begin
			pwr_r <= sleep_req ? gio_pkg::PWR_SLEEP : gio_pkg::PWR_RUN;
			if (wr_dir) dir_r <= upd(dir_r, w_data_r, w_strb_r);
			if (wr_dout) dout_r <= upd(dout_r, w_data_r, w_strb_r);
			if (wr_pen) per_en_r <= wm[NPER-1:0];
			if (wr_ctrl) rf_en_r <= wm[gio_pkg::CTRL_RF_BIT];
		end
	end

	// Configuration registers; pull-ups untouched by sleep
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			pull_r <= gio_pkg::PULL_RST;
			edge_r <= gio_pkg::EDGE_RST;
			ien_r <= '0;
			alt_r <= '0;
			rel_r <= '0;
			do_r <= '0;
		end else begin
			if (wr_pull) pull_r <= upd(pull_r, w_data_r, w_strb_r);
			if (wr_edge) edge_r <= upd(edge_r, w_data_r, w_strb_r);
			if (wr_ien) ien_r <= upd(ien_r, w_data_r, w_strb_r);
			if (wr_alt) alt_r <= wm[NPER-1:0];
			if (wr_rel) rel_r <= upd(rel_r, w_data_r, w_strb_r);
			if (wr_do) do_r <= wm[NDO-1:0];
		end
	end

	// Registered pin drive, status, interrupt and wake
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			oe_r <= '0;
			out_r <= '0;
			istat_r <= '0;
			irq_r <= 1'b0;
			wake_r <= 1'b0;
		end else begin
			oe_r <= eff_oe;
			out_r <= eff_out;
			istat_r <= istat_nxt;
			irq_r <= irq_nxt;
			wake_r <= !running && irq_nxt;
		end
	end

	// Outputs straight from flip-flops
	assign awready = awready_r;
	assign wready = wready_r;
	assign bvalid = bvalid_r;
	assign bresp = bresp_r;
	assign arready = arready_r;
	assign rvalid = rvalid_r;
	assign rdata = rdata_r;
	assign rresp = rresp_r;
	assign general_io_pin_oe = oe_r;
	assign general_io_pin_out = out_r;
	assign pin_pullup_resistor_en = pull_r;
	assign output_pin = do_r;
	assign per_enable = per_en_r;
	assign per_alt = alt_r;
	assign irq = irq_r;
	assign wake = wake_r;

	// Checks
	a_reset_state: assert property (@(posedge aclk) $rose(aresetn) |->
		(pin_pullup_resistor_en == {NPIN{1'b1}}) && (general_io_pin_oe == '0) && (per_enable == '0))
		else $error("reset state wrong");
	a_claim_drive: assert property (@(posedge aclk) disable iff (!aresetn) 1'b1 |=>
		((general_io_pin_oe ^ $past(per_oe)) & $past(claim)) == '0)
		else $error("claimed pin not under peripheral");
	a_release_general: assert property (@(posedge aclk) disable iff (!aresetn) 1'b1 |=>
		((general_io_pin_oe ^ $past(dir_r)) & $past(rel_r & ~rf_mask)) == '0)
		else $error("released pin not general");
	a_edge_sets: assert property (@(posedge aclk) disable iff (!aresetn) (ev != '0) |=>
		((istat_r & $past(ev)) == $past(ev)))
		else $error("edge lost");
	a_wake_event: assert property (@(posedge aclk) disable iff (!aresetn)
		##1 (wake == ($past(pwr_r) == gio_pkg::PWR_SLEEP && irq)))
		else $error("wake wrong");
	a_sleep_hold: assert property (@(posedge aclk) disable iff (!aresetn)
		(!running && $past(!running)) |=> $stable(general_io_pin_oe) && $stable(general_io_pin_out))
		else $error("pins moved in sleep");
	a_wake_peroff: assert property (@(posedge aclk) disable iff (!aresetn)
		(running && $past(pwr_r) == gio_pkg::PWR_SLEEP) |-> per_enable == '0 && general_io_pin_oe == dir_r)
		else $error("peripheral on after wake");
	a_rf_tx: assert property (@(posedge aclk) disable iff (!aresetn) rf_en_r |=>
		general_io_pin_oe[gio_pkg::RF_TX_PIN] && general_io_pin_out[gio_pkg::RF_TX_PIN] == $past(radio_tx_active))
		else $error("transmit indicator wrong");
	a_rf_rx: assert property (@(posedge aclk) disable iff (!aresetn) rf_en_r |=>
		general_io_pin_oe[gio_pkg::RF_RX_PIN] && general_io_pin_out[gio_pkg::RF_RX_PIN] == $past(radio_rx_active))
		else $error("receive indicator wrong");
	a_clear_drops: assert property (@(posedge aclk) disable iff (!aresetn) wr_iclr |=>
		(istat_r & $past(wm[NPIN-1:0] & ~ev)) == '0)
		else $error("status clear lost");
	a_pin_read: assert property (@(posedge aclk) disable iff (!aresetn)
		(ar_got && ra == gio_pkg::A_PIN) |=> rdata[NPIN-1:0] == $past(lvl))
		else $error("pin readback wrong");
endmodule
`default_nettype wire

// ==== hdl/gio_fix_note.sv ====
// Purpose: Empty unit that holds no module
// Assumes: Nothing
// Notes: Kept so the source list stays fixed
`timescale 1ns/1ps
`default_nettype none
`default_nettype wire

// ==== verification/gio_board.sv ====
// Purpose: Board model that resolves the level seen on each general pin
// Assumes: One clock; only the pull-up holds an undriven pin at a known level
// Notes: An undriven pin without pull-up toggles so that no stale level reads back
`timescale 1ns/1ps
`default_nettype none
module gio_board (
	// Clock
	input wire logic aclk,
	// Device drive
	input wire logic [gio_pkg::NPIN-1:0] oe,
	input wire logic [gio_pkg::NPIN-1:0] dout,
	input wire logic [gio_pkg::NPIN-1:0] pu,
	// External sources on the board
	input wire logic [gio_pkg::NPIN-1:0] ext_en,
	input wire logic [gio_pkg::NPIN-1:0] ext_val,
	// Resolved level
	output logic [gio_pkg::NPIN-1:0] pin
);
	logic float_r = 1'b0;
	// Floating level changes every cycle
	always_ff @(posedge aclk) float_r <= ~float_r;
	// External source first, then the device, then the pull-up
	assign pin = (ext_en & ext_val) | (~ext_en & oe & dout) | (~ext_en & ~oe & (pu | {gio_pkg::NPIN{float_r}}));
endmodule
`default_nettype wire

// ==== verification/gio_port_test.sv ====
// Purpose: Self-checking bench of the general I/O port
// Assumes: Bus replies come within a few cycles; pins reach status 3 edges after a change
// Notes: Reset, then register table rows, then reset, pins, interrupts, peripherals, radio, sleep
`timescale 1ns/1ps
`default_nettype none
`define CHK(n, e, g) begin cmp_count++; if ((g) !== (e)) begin errors++; $display("mismatch %s exp %h got %h", n, e, g); end end
module gio_port_test;
	typedef struct {logic [7:0] a; logic [31:0] d; logic [31:0] q; logic [1:0] rs;} gio_row_t;
	logic aclk = 1'b0, aresetn = 1'b0, awvalid = 1'b0, wvalid = 1'b0, arvalid = 1'b0, sleep_req = 1'b0;
	logic [7:0] awaddr = 8'h00, araddr = 8'h00;
	logic [31:0] wdata = 32'h0, rd = 32'h0;
	logic [1:0] wr_resp, rd_resp;
	logic awready, wready, bvalid, arready, rvalid, wake, irq, tx = 1'b0, rx = 1'b0;
	logic [1:0] bresp, rresp, output_pin;
	logic [31:0] rdata;
	logic [19:0] pin, oe, out, pu, ext_en = 20'h0, ext_val = 20'h0, per_oe = 20'h0, per_out = 20'h0;
	logic [3:0] per_enable, per_alt;
	logic [79:0] std_m = 80'h0, alt_m = 80'h0;
	int errors = 0, cmp_count = 0;
	gio_row_t rows[10] = '{
		'{gio_pkg::A_DIR, 32'hffffffff, 32'h000fffff, 2'h0},
		'{gio_pkg::A_DOUT, 32'h000a5a5a, 32'h000a5a5a, 2'h0},
		'{gio_pkg::A_PULL, 32'h00012345, 32'h00012345, 2'h0},
		'{gio_pkg::A_EDGE, 32'h000f0f0f, 32'h000f0f0f, 2'h0},
		'{gio_pkg::A_IEN, 32'h00000000, 32'h00000000, 2'h0},
		'{gio_pkg::A_ICLR, 32'h000fffff, 32'h00000000, 2'h0},
		'{gio_pkg::A_PER_ALT, 32'h0000000f, 32'h0000000f, 2'h0},
		'{gio_pkg::A_PER_REL, 32'h00000300, 32'h00000300, 2'h0},
		'{gio_pkg::A_DO, 32'h00000003, 32'h00000003, 2'h0},
		'{8'h34, 32'h00000001, 32'h00000000, 2'h2}};
	gio_port i_gio_port (.aclk(aclk), .aresetn(aresetn), .awaddr(awaddr), .awvalid(awvalid), .awready(awready),
		.wdata(wdata), .wstrb(4'hf), .wvalid(wvalid), .wready(wready), .bresp(bresp), .bvalid(bvalid),
		.bready(1'b1), .araddr(araddr), .arvalid(arvalid), .arready(arready), .rdata(rdata), .rresp(rresp),
		.rvalid(rvalid), .rready(1'b1), .general_io_pin_in(pin), .general_io_pin_out(out),
		.general_io_pin_oe(oe), .pin_pullup_resistor_en(pu), .output_pin(output_pin), .per_enable(per_enable),
		.per_alt(per_alt), .per_std_mask(std_m), .per_alt_mask(alt_m), .per_oe(per_oe), .per_out(per_out),
		.radio_tx_active(tx), .radio_rx_active(rx), .sleep_req(sleep_req), .wake(wake), .irq(irq));
	gio_board i_gio_board (.aclk(aclk), .oe(oe), .dout(out), .pu(pu), .ext_en(ext_en), .ext_val(ext_val), .pin(pin));
	// Clock of 5 ns
	always #2.5 aclk = ~aclk;
	// Write; ready lines never drop in the edge that answers, so no double assignment
	task automatic wr(input logic [7:0] a, input logic [31:0] d);
		int n;
		n = 0;
		awaddr <= a;
		wdata <= d;
		awvalid <= 1'b1;
		wvalid <= 1'b1;
		do begin
			@(posedge aclk);
			n++;
			if (awvalid && awready) awvalid <= 1'b0;
			if (wvalid && wready) wvalid <= 1'b0;
		end while (bvalid !== 1'b1 && n < 60);
		wr_resp = bresp;
		if (n >= 60) errors++;
	endtask
	// Read; data taken at the edge where rvalid is sampled
	task automatic rdt(input logic [7:0] a);
		int n;
		n = 0;
		araddr <= a;
		arvalid <= 1'b1;
		do begin
			@(posedge aclk);
			n++;
			if (arvalid && arready) arvalid <= 1'b0;
		end while (rvalid !== 1'b1 && n < 60);
		rd = rdata;
		rd_resp = rresp;
		if (n >= 60) errors++;
	endtask
	// Synchronous reset held for 10 cycles; checked while still held
	task automatic do_reset;
		aresetn <= 1'b0;
		repeat (9) @(posedge aclk);
		#1;
		`CHK("oe_rst", 20'h0, oe)
		`CHK("pu_rst", 20'hfffff, pu)
		`CHK("per_rst", 4'h0, per_enable)
		`CHK("misc_rst", 10'h000, {irq, wake, output_pin, bvalid, rvalid, per_alt})
		@(posedge aclk);
		aresetn <= 1'b1;
		@(posedge aclk);
	endtask
	task automatic finish_test;
		$display("comparisons %0d errors %0d", cmp_count, errors);
		if (errors == 0 && cmp_count > 0) $display("Run complete: PASS");
		else $display("Run complete: FAIL");
		$finish;
	endtask
	// Watchdog
	initial begin
		#200000;
		errors++;
		finish_test();
	end
	// Main sequence
	initial begin
		do_reset();
		foreach (rows[i]) begin
			wr(rows[i].a, rows[i].d);
			rdt(rows[i].a);
			`CHK("row_data", rows[i].q, rd)
			`CHK("row_resp", {rows[i].rs, rows[i].rs}, {wr_resp, rd_resp})
		end
		`CHK("do_pins", 2'h3, output_pin)
		`CHK("oe_tab", 20'hfffff, oe)
		`CHK("pu_tab", 20'h12345, pu)
		do_reset();
		rdt(gio_pkg::A_PULL);
		`CHK("pull_rst", 32'h000fffff, rd)
		// Pins 0..3 outputs without pull-up, 16..19 driven from outside
		wr(gio_pkg::A_DIR, 32'h0000000f);
		wr(gio_pkg::A_DOUT, 32'h00000005);
		wr(gio_pkg::A_PULL, 32'h000ffff0);
		ext_en <= 20'hf0000;
		ext_val <= 20'ha0000;
		repeat (5) @(posedge aclk);
		`CHK("oe_dir", 20'h0000f, oe)
		`CHK("out_dout", 5'h05, out[4:0])
		rdt(gio_pkg::A_PIN);
		`CHK("pin_read", 32'h000afff5, rd)
		// Pins 16 and 18 fell above; pin 4 rising enabled, pin 5 falling masked, pin 4 falls first
		wr(gio_pkg::A_EDGE, 32'h00000010);
		wr(gio_pkg::A_IEN, 32'h00000010);
		ext_en <= 20'hf0030;
		ext_val <= 20'ha0000;
		repeat (6) @(posedge aclk);
		rdt(gio_pkg::A_ISTAT);
		`CHK("istat_fall", 32'h00050020, rd)
		`CHK("irq_mask", 1'b0, irq)
		ext_val <= 20'ha0010;
		repeat (10) @(posedge aclk);
		rdt(gio_pkg::A_ISTAT);
		`CHK("istat_rise", 32'h00050030, rd)
		`CHK("irq_on", 1'b1, irq)
		wr(gio_pkg::A_ICLR, 32'h000f0030);
		rdt(gio_pkg::A_ISTAT);
		`CHK("istat_clr", 32'h00000000, rd)
		`CHK("irq_off", 1'b0, irq)
		// Peripheral 0 claims pin 8, or pin 9 in its alternative allocation
		std_m[8] <= 1'b1;
		alt_m[9] <= 1'b1;
		per_oe <= 20'h00300;
		per_out <= 20'h00300;
		wr(gio_pkg::A_PER_EN, 32'h00000001);
		@(posedge aclk);
		`CHK("per_claim", 4'hb, {per_enable[0], oe[9:8], out[8]})
		wr(gio_pkg::A_PER_ALT, 32'h00000001);
		@(posedge aclk);
		`CHK("per_alt", 3'h6, {per_alt[0], oe[9:8]})
		wr(gio_pkg::A_PER_ALT, 32'h00000000);
		wr(gio_pkg::A_PER_REL, 32'h00000100);
		@(posedge aclk);
		`CHK("per_rel", 1'b0, oe[8])
		wr(gio_pkg::A_PER_REL, 32'h00000000);
		// Radio indicators on pins 3 and 2
		wr(gio_pkg::A_CTRL, 32'h00000001);
		tx <= 1'b1;
		repeat (2) @(posedge aclk);
		`CHK("rf_tx", 4'he, {oe[3:2], out[3:2]})
		tx <= 1'b0;
		rx <= 1'b1;
		repeat (2) @(posedge aclk);
		`CHK("rf_rx", 4'hd, {oe[3:2], out[3:2]})
		// Sleep holds the combined drive; later changes have no effect
		sleep_req <= 1'b1;
		repeat (3) @(posedge aclk);
		per_out <= 20'h0;
		wr(gio_pkg::A_DIR, 32'h00000000);
		`CHK("sleep_wr", 2'h0, wr_resp)
		repeat (2) @(posedge aclk);
		`CHK("hold_oe", 20'h0010f, oe)
		`CHK("hold_out", 20'h00105, out & 20'h0010f)
		`CHK("per_off", 4'h0, per_enable)
		ext_val <= 20'ha0000;
		repeat (6) @(posedge aclk);
		`CHK("wake_idle", 1'b0, wake)
		ext_val <= 20'ha0010;
		repeat (6) @(posedge aclk);
		`CHK("wake", 1'b1, wake)
		sleep_req <= 1'b0;
		repeat (3) @(posedge aclk);
		`CHK("wake_off", 1'b0, wake)
		rdt(gio_pkg::A_DIR);
		`CHK("dir_wake", 32'h0000010f, rd)
		rdt(gio_pkg::A_DOUT);
		`CHK("dout_wake", 32'h00000105, rd & 32'h0000010f)
		rdt(gio_pkg::A_PER_EN);
		`CHK("per_wake", 32'h0, rd)
		rdt(gio_pkg::A_PULL);
		`CHK("pull_kept", 32'h000ffff0, rd)
		`CHK("oe_wake", 20'h0010f, oe)
		finish_test();
	end
endmodule
`default_nettype wire
